// >>> common/toh_ovh_if.sv
// overhead insertion port wires between the device and the external party
interface toh_ovh_if;
    logic ovh_port_clk;
    logic ovh_port_ready;
    logic ovh_frame_mark;
    logic ovh_serial_in;
    logic ovh_insert_req;

    modport dev (
        output ovh_port_clk,
        output ovh_port_ready,
        output ovh_frame_mark,
        input  ovh_serial_in,
        input  ovh_insert_req
    );

    modport ext (
        input  ovh_port_clk,
        input  ovh_port_ready,
        input  ovh_frame_mark,
        output ovh_serial_in,
        output ovh_insert_req
    );
endinterface : toh_ovh_if

// >>> common/toh_pkg.sv
// shared constants, types and helpers for the overhead insertion port
package toh_pkg;

    localparam int CLK_PERIOD_NS = 20;
    localparam int FRAME_TIME_NS = 125000;
    localparam int FRAME_CYCLES  = FRAME_TIME_NS / CLK_PERIOD_NS;

    // port clock is core clock divided by 2 * PCLK_HALF
    localparam int PCLK_HALF     = 3;
    localparam int PCLK_CNT_W    = 2;

    // link side reset is stretched so the port clock can carry it over
    localparam int                LRST_W      = 5;
    localparam logic [LRST_W-1:0] LRST_CYCLES = 5'h1F;

    localparam int BYTE_W        = 8;
    localparam int TOH_ROWS      = 9;
    localparam int TOH_COLS      = 3;
    localparam int TOH_BYTES     = TOH_ROWS * TOH_COLS;
    localparam int TOH_BITS      = TOH_BYTES * BYTE_W;
    localparam int BYTE_IDX_W    = 5;
    localparam int BIT_POS_W     = 3;
    localparam int BIT_IDX_W     = BYTE_IDX_W + BIT_POS_W;
    localparam int PCNT_W        = 16;
    localparam int STS_W         = 2;

    localparam logic [STS_W-1:0]     FIRST_STS    = 2'h0;
    localparam logic [BIT_POS_W-1:0] LAST_BIT_POS = 3'h7;
    localparam logic [BIT_IDX_W-1:0] TOH_BITS_V   = 8'hD8;
    localparam logic [BYTE_IDX_W-1:0] TOH_BYTES_V = 5'h1B;

    // ready stays one extra period to catch the bit driven in the last one
    localparam int READY_PERIODS = TOH_BITS + 1;

    typedef enum logic [2:0] {
        ST_WAIT = 3'h1,
        ST_MARK = 3'h2,
        ST_OPEN = 3'h4
    } toh_dev_state_t;

    function automatic logic [BYTE_IDX_W-1:0] byte_of(
        input logic [BIT_IDX_W-1:0] idx);
        byte_of = idx[BIT_IDX_W-1:BIT_POS_W];
    endfunction : byte_of

    function automatic logic [BIT_POS_W-1:0] bit_of(
        input logic [BIT_IDX_W-1:0] idx);
        bit_of = idx[BIT_POS_W-1:0];
    endfunction : bit_of

endpackage : toh_pkg

// >>> logic/toh_dev.sv
// device end: drives the port clock, collects overhead, substitutes it
module toh_dev #(
    parameter int FRAME_CYCLES = toh_pkg::FRAME_CYCLES
) (
    input  logic                           core_clk_i,
    input  logic                           reset_i,
    toh_ovh_if.dev                         ovh,
    input  logic                           tx_valid_i,
    input  logic [toh_pkg::BYTE_W-1:0]     tx_data_i,
    input  logic                           tx_is_toh_i,
    input  logic [toh_pkg::STS_W-1:0]      tx_sts_i,
    input  logic [toh_pkg::BYTE_IDX_W-1:0] tx_toh_idx_i,
    output logic                           tx_valid_o,
    output logic [toh_pkg::BYTE_W-1:0]     tx_data_o,
    output logic                           tx_ins_o
);
    localparam int FRAME_PCLK = FRAME_CYCLES / (2 * toh_pkg::PCLK_HALF);
    localparam logic [toh_pkg::PCNT_W-1:0] MARK_PERIOD =
        toh_pkg::PCNT_W'(FRAME_PCLK - 1);
    localparam logic [toh_pkg::PCNT_W-1:0] PRE_MARK_PERIOD =
        toh_pkg::PCNT_W'(FRAME_PCLK - 2);
    localparam logic [toh_pkg::PCNT_W-1:0] READY_LAST =
        toh_pkg::PCNT_W'(toh_pkg::READY_PERIODS - 1);

    logic                       pclk;
    logic                       rise;
    logic                       fall;
    logic [toh_pkg::PCNT_W-1:0] period;

    toh_frame_ctr #(
        .FRAME_CYCLES (FRAME_CYCLES)
    ) u_frame_ctr (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i),
        .pclk_o     (pclk),
        .rise_o     (rise),
        .fall_o     (fall),
        .period_o   (period)
    );

    // the port clock flop leaves the block unbuffered
    assign ovh.ovh_port_clk = pclk;

    // ---------------- pin synchronisers ----------------
    logic req_s1;
    logic req_s2;
    logic sdi_s1;
    logic sdi_s2;

    // with PCLK_HALF of 3 the second stage settles before the next rise
    always_ff @(posedge core_clk_i) begin
        req_s1 <= ovh.ovh_insert_req;
        req_s2 <= req_s1;
        sdi_s1 <= ovh.ovh_serial_in;
        sdi_s2 <= sdi_s1;
    end

    // ---------------- frame state ----------------
    toh_pkg::toh_dev_state_t state;
    toh_pkg::toh_dev_state_t next_state;
    logic                    mark;
    logic                    next_mark;
    logic                    ready;
    logic                    next_ready;
    logic                    frame_start;

    always_comb begin
        next_state  = state;
        frame_start = 1'b0;
        if (fall) begin
            case (state)
                toh_pkg::ST_WAIT: begin
                    if (period == PRE_MARK_PERIOD) begin
                        next_state  = toh_pkg::ST_MARK;
                        frame_start = 1'b1;
                    end
                end
                toh_pkg::ST_MARK: begin
                    if (period == MARK_PERIOD) begin
                        next_state = toh_pkg::ST_OPEN;
                    end
                end
                toh_pkg::ST_OPEN: begin
                    if (period == READY_LAST) begin
                        next_state = toh_pkg::ST_WAIT;
                    end
                end
                default: begin
                    next_state = toh_pkg::ST_WAIT;
                end
            endcase
        end
        // outputs change on the falling edge so they are steady at rise
        next_mark  = (next_state == toh_pkg::ST_MARK);
        next_ready = (next_state == toh_pkg::ST_OPEN);
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            state <= toh_pkg::ST_WAIT;
            mark  <= 1'b0;
            ready <= 1'b0;
        end else begin
            state <= next_state;
            mark  <= next_mark;
            ready <= next_ready;
        end
    end

    assign ovh.ovh_frame_mark = mark;
    assign ovh.ovh_port_ready = ready;

    // ---------------- bit assembly ----------------
    logic [toh_pkg::BYTE_W-1:0]    asm_mem [toh_pkg::TOH_BYTES];
    logic [toh_pkg::BYTE_W-1:0]    next_asm_mem [toh_pkg::TOH_BYTES];
    logic [toh_pkg::TOH_BYTES-1:0] asm_vld;
    logic [toh_pkg::TOH_BYTES-1:0] next_asm_vld;
    logic [toh_pkg::BYTE_W-1:0]    act_mem [toh_pkg::TOH_BYTES];
    logic [toh_pkg::BYTE_W-1:0]    next_act_mem [toh_pkg::TOH_BYTES];
    logic [toh_pkg::TOH_BYTES-1:0] act_vld;
    logic [toh_pkg::TOH_BYTES-1:0] next_act_vld;
    logic [toh_pkg::BYTE_W-1:0]    shift;
    logic [toh_pkg::BYTE_W-1:0]    next_shift;
    logic [toh_pkg::BIT_IDX_W-1:0] bit_idx;
    logic [toh_pkg::BIT_IDX_W-1:0] next_bit_idx;
    logic                          capture;

    always_comb begin
        next_asm_mem = asm_mem;
        next_asm_vld = asm_vld;
        next_act_mem = act_mem;
        next_act_vld = act_vld;
        next_shift   = shift;
        next_bit_idx = bit_idx;
        // sampling only on rise, and only with ready and request both high
        capture = rise && ready && req_s2
                  && (bit_idx < toh_pkg::TOH_BITS_V);
        if (frame_start) begin
            // the finished frame becomes the one used for insertion
            next_act_mem = asm_mem;
            next_act_vld = asm_vld;
            next_asm_vld = '0;
            next_bit_idx = '0;
        end else if (capture) begin
            next_shift   = {shift[toh_pkg::BYTE_W-2:0], sdi_s2};
            next_bit_idx = bit_idx + 1'b1;
            if (toh_pkg::bit_of(bit_idx) == toh_pkg::LAST_BIT_POS) begin
                next_asm_mem[toh_pkg::byte_of(bit_idx)] =
                    {shift[toh_pkg::BYTE_W-2:0], sdi_s2};
                next_asm_vld[toh_pkg::byte_of(bit_idx)] = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            asm_vld <= '0;
            act_vld <= '0;
            shift   <= '0;
            bit_idx <= '0;
        end else begin
            asm_vld <= next_asm_vld;
            act_vld <= next_act_vld;
            shift   <= next_shift;
            bit_idx <= next_bit_idx;
        end
    end

    // data arrays need no reset; the valid bits guard them
    always_ff @(posedge core_clk_i) begin
        asm_mem <= next_asm_mem;
        act_mem <= next_act_mem;
    end

    // ---------------- outbound substitution ----------------
    logic                       hit;
    logic                       next_tx_valid;
    logic [toh_pkg::BYTE_W-1:0] next_tx_data;
    logic                       next_tx_ins;

    always_comb begin
        // other constituents keep their generated overhead
        hit = tx_valid_i && tx_is_toh_i
              && (tx_sts_i == toh_pkg::FIRST_STS)
              && (tx_toh_idx_i < toh_pkg::TOH_BYTES_V)
              && act_vld[tx_toh_idx_i];
        next_tx_valid = tx_valid_i;
        next_tx_data  = hit ? act_mem[tx_toh_idx_i] : tx_data_i;
        next_tx_ins   = hit;
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            tx_valid_o <= 1'b0;
            tx_data_o  <= '0;
            tx_ins_o   <= 1'b0;
        end else begin
            tx_valid_o <= next_tx_valid;
            tx_data_o  <= next_tx_data;
            tx_ins_o   <= next_tx_ins;
        end
    end
endmodule : toh_dev

// >>> logic/toh_ext.sv
// external end: user table in core domain, serial driver on port clock
module toh_ext (
    input  logic                           core_clk_i,
    input  logic                           reset_i,
    toh_ovh_if.ext                         ovh,
    input  logic                           usr_wr_i,
    input  logic [toh_pkg::BYTE_IDX_W-1:0] usr_idx_i,
    input  logic [toh_pkg::BYTE_W-1:0]     usr_byte_i,
    input  logic                           usr_commit_i,
    input  logic                           usr_en_i,
    output logic                           usr_busy_o
);
    // ---------------- core domain ----------------
    logic [toh_pkg::BYTE_W-1:0] cmem [toh_pkg::TOH_BYTES];
    logic [toh_pkg::BYTE_W-1:0] next_cmem [toh_pkg::TOH_BYTES];
    logic                       req_tgl;
    logic                       next_req_tgl;
    logic                       ack_c1;
    logic                       ack_c2;
    logic                       next_busy;
    logic                       ack_tgl;
    logic [toh_pkg::LRST_W-1:0] lrst_cnt;
    logic [toh_pkg::LRST_W-1:0] next_lrst_cnt;
    logic                       link_rst;
    logic                       next_link_rst;

    always_comb begin
        next_cmem    = cmem;
        next_req_tgl = req_tgl;
        // table is frozen while the link side copies it
        if (!usr_busy_o) begin
            if (usr_wr_i && (usr_idx_i < toh_pkg::TOH_BYTES_V)) begin
                next_cmem[usr_idx_i] = usr_byte_i;
            end
            if (usr_commit_i) begin
                next_req_tgl = ~req_tgl;
            end
        end
        // port clock stands still in reset: hold the link side a while
        next_lrst_cnt = (lrst_cnt == '0) ? lrst_cnt : lrst_cnt - 1'b1;
        next_link_rst = (lrst_cnt != '0);
        // busy also covers the link reset, so no write is lost to it
        next_busy = link_rst | (next_req_tgl ^ ack_c2);
    end

    always_ff @(posedge core_clk_i) begin
        ack_c1 <= ack_tgl;
        ack_c2 <= ack_c1;
        cmem   <= next_cmem;
        if (reset_i) begin
            req_tgl    <= 1'b0;
            usr_busy_o <= 1'b1;
            lrst_cnt   <= toh_pkg::LRST_CYCLES;
            link_rst   <= 1'b1;
        end else begin
            req_tgl    <= next_req_tgl;
            usr_busy_o <= next_busy;
            lrst_cnt   <= next_lrst_cnt;
            link_rst   <= next_link_rst;
        end
    end

    // ---------------- link domain ----------------
    logic                          rst_l1;
    logic                          rst_l2;
    logic                          req_l1;
    logic                          req_l2;
    logic                          en_l1;
    logic                          en_l2;
    logic                          seen_ready;
    logic                          seen_mark;
    logic [toh_pkg::BYTE_W-1:0]    lmem [toh_pkg::TOH_BYTES];
    logic [toh_pkg::BYTE_W-1:0]    next_lmem [toh_pkg::TOH_BYTES];
    logic                          next_ack_tgl;

    always_comb begin
        next_lmem    = lmem;
        next_ack_tgl = ack_tgl;
        if (req_l2 != ack_tgl) begin
            next_lmem    = cmem;
            next_ack_tgl = req_l2;
        end
    end

    // port outputs of the device are sampled on each rising edge
    always_ff @(posedge ovh.ovh_port_clk) begin
        rst_l1 <= link_rst;
        rst_l2 <= rst_l1;
        req_l1 <= req_tgl;
        req_l2 <= req_l1;
        en_l1  <= usr_en_i;
        en_l2  <= en_l1;
        lmem   <= next_lmem;
        if (rst_l2) begin
            ack_tgl    <= 1'b0;
            seen_ready <= 1'b0;
            seen_mark  <= 1'b0;
        end else begin
            ack_tgl    <= next_ack_tgl;
            seen_ready <= ovh.ovh_port_ready;
            seen_mark  <= ovh.ovh_frame_mark;
        end
    end

    logic [toh_pkg::BIT_IDX_W-1:0] idx;
    logic [toh_pkg::BIT_IDX_W-1:0] next_idx;
    logic                          drv_req;
    logic                          next_drv_req;
    logic                          drv_bit;
    logic                          next_drv_bit;

    always_comb begin
        next_idx     = idx;
        next_drv_req = 1'b0;
        next_drv_bit = drv_bit;
        if (seen_mark) begin
            // supply starts only at a frame boundary so bits keep slots
            next_idx = en_l2 ? '0 : toh_pkg::TOH_BITS_V;
        end else if (seen_ready && en_l2
                     && (idx < toh_pkg::TOH_BITS_V)) begin
            next_drv_req = 1'b1;
            next_drv_bit = lmem[toh_pkg::byte_of(idx)]
                [toh_pkg::LAST_BIT_POS - toh_pkg::bit_of(idx)];
            next_idx     = idx + 1'b1;
        end
    end

    // request and bit change on the falling edge, half a period of margin
    always_ff @(negedge ovh.ovh_port_clk) begin
        if (rst_l2) begin
            idx     <= toh_pkg::TOH_BITS_V;
            drv_req <= 1'b0;
            drv_bit <= 1'b0;
        end else begin
            idx     <= next_idx;
            drv_req <= next_drv_req;
            drv_bit <= next_drv_bit;
        end
    end

    assign ovh.ovh_insert_req = drv_req;
    assign ovh.ovh_serial_in  = drv_bit;
endmodule : toh_ext

// >>> logic/toh_frame_ctr.sv
// port clock divider and frame period counter
module toh_frame_ctr #(
    parameter int FRAME_CYCLES = toh_pkg::FRAME_CYCLES
) (
    input  logic                       core_clk_i,
    input  logic                       reset_i,
    output logic                       pclk_o,
    output logic                       rise_o,
    output logic                       fall_o,
    output logic [toh_pkg::PCNT_W-1:0] period_o
);
    localparam int FRAME_PCLK = FRAME_CYCLES / (2 * toh_pkg::PCLK_HALF);
    localparam logic [toh_pkg::PCNT_W-1:0] LAST_PERIOD =
        toh_pkg::PCNT_W'(FRAME_PCLK - 1);
    localparam logic [toh_pkg::PCLK_CNT_W-1:0] DIV_LAST =
        toh_pkg::PCLK_CNT_W'(toh_pkg::PCLK_HALF - 1);

    logic [toh_pkg::PCLK_CNT_W-1:0] div;
    logic [toh_pkg::PCLK_CNT_W-1:0] next_div;
    logic                           pclk;
    logic                           next_pclk;
    logic [toh_pkg::PCNT_W-1:0]     period;
    logic [toh_pkg::PCNT_W-1:0]     next_period;
    logic                           wrap;

    always_comb begin
        wrap        = (div == DIV_LAST);
        next_div    = wrap ? '0 : div + 1'b1;
        next_pclk   = pclk ^ wrap;
        next_period = period;
        // a new period begins at each falling edge of the port clock
        if (wrap && pclk) begin
            next_period = (period == LAST_PERIOD) ? '0 : period + 1'b1;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            div    <= '0;
            pclk   <= 1'b0;
            period <= '0;
        end else begin
            div    <= next_div;
            pclk   <= next_pclk;
            period <= next_period;
        end
    end

    assign pclk_o   = pclk;
    assign rise_o   = wrap & ~pclk;
    assign fall_o   = wrap & pclk;
    assign period_o = period;
endmodule : toh_frame_ctr

// >>> sim/toh_checker.sv
// link assertions for the overhead insertion port
module toh_checker #(
    parameter int FRAME_CYCLES = toh_pkg::FRAME_CYCLES
) (
    input logic core_clk_i,
    input logic reset_i,
    input logic ovh_port_clk,
    input logic ovh_port_ready,
    input logic ovh_frame_mark,
    input logic ovh_serial_in,
    input logic ovh_insert_req
);
    localparam int FP = FRAME_CYCLES / (2 * toh_pkg::PCLK_HALF);
    logic [15:0] rdy_n;
    logic [15:0] gap;
    logic        seen;

    // async clear: the port clock stands still while reset is high
    always_ff @(posedge ovh_port_clk or posedge reset_i) begin
        if (reset_i) begin
            rdy_n <= 16'h0;
            gap   <= 16'h0;
            seen  <= 1'b0;
        end else begin
            rdy_n <= ovh_port_ready ? rdy_n + 16'h1 : 16'h0;
            gap   <= ovh_frame_mark ? 16'h1 : gap + 16'h1;
            seen  <= seen | ovh_frame_mark;
        end
    end

    sequence s_hi3;
        ovh_port_clk [*3];
    endsequence
    sequence s_lo3;
        !ovh_port_clk [*3];
    endsequence

    AST_PCLK_RISE: assert property (
        @(posedge core_clk_i) disable iff (reset_i)
        $rose(ovh_port_clk) |-> s_hi3 ##1 s_lo3 ##1 ovh_port_clk)
        else $error("port clock high phase or next low phase wrong");
    AST_PCLK_FALL: assert property (
        @(posedge core_clk_i) disable iff (reset_i)
        $fell(ovh_port_clk) |-> s_lo3 ##1 s_hi3)
        else $error("port clock low phase or next high phase wrong");
    AST_EXT_EDGE: assert property (
        @(posedge core_clk_i) disable iff (reset_i)
        $changed(ovh_serial_in) || $changed(ovh_insert_req)
        |-> $fell(ovh_port_clk))
        else $error("serial or request changed off the falling edge");
    AST_MARK_ONE: assert property (
        @(posedge ovh_port_clk) disable iff (reset_i)
        ovh_frame_mark |=> !ovh_frame_mark && ovh_port_ready)
        else $error("mark not one period followed by ready");
    AST_READY_AFTER_MARK: assert property (
        @(posedge ovh_port_clk) disable iff (reset_i)
        $rose(ovh_port_ready) |-> $past(ovh_frame_mark))
        else $error("ready rose without mark in previous period");
    AST_READY_LEN: assert property (
        @(posedge ovh_port_clk) disable iff (reset_i)
        $fell(ovh_port_ready) |-> rdy_n == toh_pkg::READY_PERIODS)
        else $error("ready window length wrong");
    AST_FRAME_LEN: assert property (
        @(posedge ovh_port_clk) disable iff (reset_i)
        ovh_frame_mark && seen |-> gap == FP)
        else $error("frame mark spacing wrong");
    AST_REQ_IN_READY: assert property (
        @(posedge ovh_port_clk) disable iff (reset_i)
        ovh_insert_req |-> ovh_port_ready)
        else $error("request high outside ready");
    AST_REQ_START: assert property (
        @(posedge ovh_port_clk) disable iff (reset_i)
        $rose(ovh_insert_req)
        |-> $past(ovh_port_ready) && !$past(ovh_port_ready, 2))
        else $error("request not one period after ready rose");
    AST_REQ_RUN: assert property (
        @(posedge ovh_port_clk) disable iff (reset_i)
        $rose(ovh_insert_req) |-> ovh_insert_req [*8])
        else $error("bits not back to back");
endmodule : toh_checker

// >>> sim/tx_overhead_serial_insert_port_bench.sv
// bench joining device and external ends with a model of the tx path
module tx_overhead_serial_insert_port_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int FC    = 1440;
    localparam int LIMIT = 40000;
    logic       core_clk_i, reset_i, tx_valid_i, tx_is_toh_i;
    logic       tx_valid_o, tx_ins_o, usr_wr_i, usr_commit_i;
    logic       usr_en_i, usr_busy_o, exp_v, exp_i, sub, chk_on, ins_on;
    logic [7:0] tx_data_i, tx_data_o, usr_byte_i, exp_d;
    logic [7:0] tbl [27];
    logic [1:0] tx_sts_i;
    logic [4:0] tx_toh_idx_i, usr_idx_i;
    int         err_total, check_count, cyc, k;

    toh_ovh_if ovh_w ();
    toh_dev #(.FRAME_CYCLES(FC)) toh_dev_i (
        .core_clk_i(core_clk_i), .reset_i(reset_i), .ovh(ovh_w),
        .tx_valid_i(tx_valid_i), .tx_data_i(tx_data_i),
        .tx_is_toh_i(tx_is_toh_i), .tx_sts_i(tx_sts_i),
        .tx_toh_idx_i(tx_toh_idx_i), .tx_valid_o(tx_valid_o),
        .tx_data_o(tx_data_o), .tx_ins_o(tx_ins_o));
    toh_ext toh_ext_i (
        .core_clk_i(core_clk_i), .reset_i(reset_i), .ovh(ovh_w),
        .usr_wr_i(usr_wr_i), .usr_idx_i(usr_idx_i),
        .usr_byte_i(usr_byte_i), .usr_commit_i(usr_commit_i),
        .usr_en_i(usr_en_i), .usr_busy_o(usr_busy_o));
    toh_checker #(.FRAME_CYCLES(FC)) toh_checker_i (
        .core_clk_i(core_clk_i), .reset_i(reset_i),
        .ovh_port_clk(ovh_w.ovh_port_clk),
        .ovh_port_ready(ovh_w.ovh_port_ready),
        .ovh_frame_mark(ovh_w.ovh_frame_mark),
        .ovh_serial_in(ovh_w.ovh_serial_in),
        .ovh_insert_req(ovh_w.ovh_insert_req));

    initial begin
        core_clk_i = 1'b0;
        forever #10 core_clk_i = ~core_clk_i;
    end

    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic end_sim;
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_sim

    // fill the user table, commit, then try a write that must be dropped
    task automatic load;
        while (usr_busy_o !== 1'b0) @(posedge core_clk_i);
        for (int i = 0; i < 27; i++) begin
            @(posedge core_clk_i);
            tbl[i] = 8'($urandom);
            usr_wr_i   <= 1'b1;
            usr_idx_i  <= 5'(i);
            usr_byte_i <= tbl[i];
        end
        @(posedge core_clk_i);
        usr_wr_i     <= 1'b0;
        usr_commit_i <= 1'b1;
        @(posedge core_clk_i);
        usr_commit_i <= 1'b0;
        @(posedge core_clk_i);
        usr_wr_i   <= 1'b1;
        usr_idx_i  <= 5'h00;
        usr_byte_i <= ~tbl[0];
        @(posedge core_clk_i);
        usr_wr_i <= 1'b0;
        for (int n = 0; n < 200 && usr_busy_o !== 1'b0; n++) begin
            @(posedge core_clk_i);
        end
        chk("usr_busy_o", 8'h00, {7'h00, usr_busy_o});
    endtask : load

    // table only settles a frame after commit, so checks start later
    task automatic window(input logic on, input int n);
        ins_on <= on;
        chk_on <= 1'b0;
        repeat (3 * FC) @(posedge core_clk_i);
        chk_on <= 1'b1;
        repeat (n) @(posedge core_clk_i);
        chk_on <= 1'b0;
    endtask : window

    always @(posedge core_clk_i) begin
        tx_valid_i   <= ($urandom % 4) != 0;
        tx_is_toh_i  <= 1'($urandom);
        tx_sts_i     <= 2'($urandom);
        tx_toh_idx_i <= 5'($urandom);
        tx_data_i    <= 8'($urandom);
    end

    always @(posedge core_clk_i) begin
        if (chk_on) begin
            chk("tx_valid_o", {7'h00, exp_v}, {7'h00, tx_valid_o});
            chk("tx_ins_o", {7'h00, exp_i}, {7'h00, tx_ins_o});
            if (exp_v) chk("tx_data_o", exp_d, tx_data_o);
        end
        sub = ins_on && tx_valid_i && tx_is_toh_i
              && tx_sts_i == toh_pkg::FIRST_STS && tx_toh_idx_i < 5'h1B;
        exp_v = tx_valid_i;
        exp_i = sub;
        exp_d = sub ? tbl[tx_toh_idx_i] : tx_data_i;
    end

    always @(posedge ovh_w.ovh_port_clk) begin
        if (ovh_w.ovh_frame_mark) begin
            if (chk_on) chk("bits", ins_on ? 8'hD8 : 8'h00, 8'(k));
            k = 0;
        end else if (ovh_w.ovh_port_ready && ovh_w.ovh_insert_req) begin
            if (chk_on && ins_on) chk("serial", {7'h00, tbl[k / 8][7 - k % 8]},
                {7'h00, ovh_w.ovh_serial_in});
            k++;
        end
    end

    always @(posedge core_clk_i) begin
        cyc++;
        if (cyc == LIMIT) begin
            err_total++;
            end_sim();
        end
    end

    initial begin
        k = $urandom(32'h289E);
        reset_i = 1'b1;
        {usr_wr_i, usr_commit_i, usr_en_i, chk_on, ins_on} = 5'h00;
        {tx_valid_i, tx_is_toh_i, tx_sts_i, tx_toh_idx_i} = 9'h000;
        {tx_data_i, usr_idx_i, usr_byte_i} = 21'h0;
        // the external end stretches reset for its link side itself
        repeat (2) @(posedge core_clk_i);
        reset_i <= 1'b0;
        load();
        window(1'b0, 1600);
        usr_en_i <= 1'b1;
        window(1'b1, 1600);
        load();
        window(1'b1, 1600);
        usr_en_i <= 1'b0;
        window(1'b0, 1600);
        end_sim();
    end
endmodule : tx_overhead_serial_insert_port_bench
